// *** rtl/tstq_defines.svh ***
// Purpose: offsets, field positions, reset values of the stamp queue
// Assumes: byte addresses on a 32-bit classic wishbone slave
// Notes:   included by every design file of the block but the package
`ifndef TSTQ_DEFINES_SVH
`define TSTQ_DEFINES_SVH
`define TSTQ_ADR_HEAD_STATUS   8'h00
`define TSTQ_ADR_HEAD_VALUE    8'h04
`define TSTQ_ADR_ADVANCE       8'h08
`define TSTQ_ADR_REL_UPPER     8'h0C
`define TSTQ_ADR_REL_LOWER     8'h10
`define TSTQ_ADR_PORT_DIS      8'h14
`define TSTQ_ADR_IRQ_STATUS    8'h18
`define TSTQ_ADR_IRQ_MASK      8'h1C
`define TSTQ_ADR_LEVEL         8'h20
`define TSTQ_F_VALID           0
`define TSTQ_F_ID_LSB          1
`define TSTQ_F_PORT_LSB        7
`define TSTQ_F_MAINT           12
`define TSTQ_F_OVFL            13
`define TSTQ_IRQ_PUSH          0
`define TSTQ_IRQ_OVFL          1
`define TSTQ_IRQ_UNTRUST       2
`define TSTQ_OP_TWO_STEP       3'h3
`define TSTQ_DEPTH             128
`define TSTQ_ID_FIRST          6'h04
`define TSTQ_ID_UNTRUST        6'h3F
`define TSTQ_POOL_RESET        64'h0000_0000_0000_000F
`define TSTQ_PORT_DIS_RESET    32'h0000_0000
`define TSTQ_IRQ_MASK_RESET    3'h0
`endif

// *** rtl/tstq_id_pool.sv ***
// Purpose: pool of 64 stamp identifiers for two-step frames
// Assumes: one allocation request per cycle at most
// Notes:   identifier 63 is handed out when nothing else is free
`timescale 1ns/10ps
`include "tstq_defines.svh"
module tstq_id_pool
    import tstq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        alloc_i,
    input  wire logic [63:0] release_i,
    output tstq_id_t         alloc_id_o,
    output logic             untrusted_o,
    output logic [63:0]      in_use_o
);
    logic [63:0] in_use;
    tstq_id_t    pick;

    // lowest free id from 4 to 62, else 63
    function automatic tstq_id_t find_free(input logic [63:0] used);
        tstq_id_t r;
        r = `TSTQ_ID_UNTRUST;
        for (int i = 62; i >= 4; i--) begin
            if (!used[i]) begin
                r = 6'(i);
            end
        end
        return r;
    endfunction

    assign pick        = find_free(in_use);
    assign alloc_id_o  = pick;
    assign untrusted_o = (pick == `TSTQ_ID_UNTRUST);
    assign in_use_o    = in_use;

    // allocation wins over a release in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_use <= `TSTQ_POOL_RESET;
        end else begin
            in_use <= (in_use & ~release_i) | `TSTQ_POOL_RESET;
            if (alloc_i && pick != `TSTQ_ID_UNTRUST) begin
                in_use[pick] <= 1'b1;
            end
        end
    end
endmodule

// *** rtl/tstq_pkg.sv ***
// Purpose: types shared by the stamp queue files
// Assumes: nothing
// Notes:   numbers live in tstq_defines.svh
package tstq_pkg;
    typedef logic [5:0]  tstq_id_t;
    typedef logic [4:0]  tstq_port_t;
    typedef logic [31:0] tstq_stamp_t;
    typedef enum logic [2:0] {
        TSTQ_IDLE = 3'b001,
        TSTQ_ACK  = 3'b010,
        TSTQ_GAP  = 3'b100
    } tstq_bus_st_t;
endpackage

// *** rtl/tstq_queue.sv ***
// Purpose: two-step transmit stamp queue with identifier pool
// Assumes: analyzer and egress stamp streams run on clk_i
// Notes:   one egress stamp per cycle; arbitration is outside
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "tstq_defines.svh"

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - rewrite code 3 triggers two-step stamping on any frame, unmodified.
// - one 128-entry stamp queue shared by all egress ports.
// - every entry has a valid flag meaning ready for software.
// - each stamped frame gets a unique 6-bit id stored in its entries.
// - extracted frames carry their id in the header's DSCP place.
// - with ids 0..62 busy the frame gets id 63, untrustworthy.
// - multicast makes one entry per port, same id, own port number.
// - maintenance source flag is always zero for two-step entries.
// - a stamp arriving at full queue is lost and sets overflow.
// - status and value registers read the oldest entry.
// - any write to advance drops the head and moves the pointer.
// - frames to processor queues make no entry, receive stamp instead.
// - ids 0..3 are reserved for injection, never allocated.
// - writing a release bit frees the id; upper 32..63, lower 0..31.
// - per-port disable suppresses two-step, overriding the classifier.
module tstq_queue
    import tstq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // analyzer side: one frame decision per pulse
    input  wire logic        frame_vld_i,
    input  wire logic [2:0]  rewrite_operation_code_i,
    input  wire logic        frame_to_cpu_i,
    input  tstq_stamp_t      frame_rx_stamp_i,
    output logic             frame_id_vld_o,
    output tstq_id_t         frame_stamp_identifier_o,
    output logic             ext_hdr_vld_o,
    output logic [5:0]       ext_hdr_dscp_o,
    output tstq_stamp_t      ext_hdr_rx_stamp_o,
    // egress side: one transmit stamp per pulse
    input  wire logic        tx_stamp_vld_i,
    input  wire logic [2:0]  tx_rewrite_operation_code_i,
    input  wire logic        tx_to_cpu_i,
    input  tstq_id_t         tx_stamp_identifier_i,
    input  tstq_port_t       tx_port_i,
    input  tstq_stamp_t      tx_stamp_i,
    output logic             irq_o
);

////////////////////////////////////////////////////////////////////////
// bus handshake

    tstq_bus_st_t bus_st;
    tstq_bus_st_t next_bus_st;
    logic         req;
    logic         wr_take;
    logic         rd_take;

    assign req     = cyc_i && stb_i;
    assign wr_take = (bus_st == TSTQ_IDLE) && req && we_i;
    assign rd_take = (bus_st == TSTQ_IDLE) && req && !we_i;

    // a gap state keeps a still-held request from being taken twice
    always_comb begin
        case (bus_st)
            TSTQ_IDLE: next_bus_st = req ? TSTQ_ACK : TSTQ_IDLE;
            TSTQ_ACK:  next_bus_st = TSTQ_GAP;
            TSTQ_GAP:  next_bus_st = req ? TSTQ_GAP : TSTQ_IDLE;
            default:   next_bus_st = TSTQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_st <= TSTQ_IDLE;
        end else begin
            bus_st <= next_bus_st;
        end
    end

    assign ack_o = (bus_st == TSTQ_ACK);

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic [31:0] lanes(input logic [3:0]  s,
                                          input logic [31:0] d);
        logic [31:0] r;
        for (int b = 0; b < 4; b++) begin
            r[b*8 +: 8] = s[b] ? d[b*8 +: 8] : 8'h00;
        end
        return r;
    endfunction

////////////////////////////////////////////////////////////////////////
// software registers

    logic [31:0] port_disable;
    logic [2:0]  irq_mask;
    logic [2:0]  irq_stat;
    logic [31:0] wr_bits;
    logic        adv_wr;
    logic [63:0] release_bits;

    assign wr_bits = lanes(sel_i, dat_i);
    assign adv_wr  = wr_take && hit(adr_i, `TSTQ_ADR_ADVANCE);

    // release bits: upper word frees 32..63, lower word 0..31
    assign release_bits = {
        (wr_take && hit(adr_i, `TSTQ_ADR_REL_UPPER)) ? wr_bits : 32'h0,
        (wr_take && hit(adr_i, `TSTQ_ADR_REL_LOWER)) ? wr_bits : 32'h0
    };

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_disable <= `TSTQ_PORT_DIS_RESET;
        end else if (wr_take && hit(adr_i, `TSTQ_ADR_PORT_DIS)) begin
            port_disable <= wr_bits;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= `TSTQ_IRQ_MASK_RESET;
        end else if (wr_take && hit(adr_i, `TSTQ_ADR_IRQ_MASK)) begin
            irq_mask <= wr_bits[2:0];
        end
    end

////////////////////////////////////////////////////////////////////////
// identifier pool and analyzer decision

    logic     frame_two_step;
    tstq_id_t pool_id;
    logic     pool_untrusted;
    logic     alloc;

    assign frame_two_step = frame_vld_i &&
        (rewrite_operation_code_i == `TSTQ_OP_TWO_STEP);
    assign alloc = frame_two_step;

    tstq_id_pool u_pool (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .alloc_i     (alloc),
        .release_i   (release_bits),
        .alloc_id_o  (pool_id),
        .untrusted_o (pool_untrusted),
        .in_use_o    ()
    );

    // the id goes back with the frame so every copy carries it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_id_vld_o           <= 1'b0;
            frame_stamp_identifier_o <= 6'h00;
        end else begin
            frame_id_vld_o <= alloc;
            if (alloc) begin
                frame_stamp_identifier_o <= pool_id;
            end
        end
    end

    // extraction header: id in the dscp slot, receive stamp beside it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_hdr_vld_o      <= 1'b0;
            ext_hdr_dscp_o     <= 6'h00;
            ext_hdr_rx_stamp_o <= 32'h0000_0000;
        end else begin
            ext_hdr_vld_o <= frame_two_step && frame_to_cpu_i;
            if (frame_two_step && frame_to_cpu_i) begin
                ext_hdr_dscp_o     <= pool_id;
                ext_hdr_rx_stamp_o <= frame_rx_stamp_i;
            end
        end
    end

////////////////////////////////////////////////////////////////////////
// egress stamps into the queue

    logic        push;
    logic        drop;
    logic        head_vld;
    tstq_id_t    head_id;
    tstq_port_t  head_port;
    tstq_stamp_t head_stamp;
    logic [7:0]  level;

    // port disable overrides the classifier; processor copies skip
    assign push = tx_stamp_vld_i &&
        (tx_rewrite_operation_code_i == `TSTQ_OP_TWO_STEP) &&
        !port_disable[tx_port_i] &&
        !tx_to_cpu_i;

    // each egress copy arrives on its own with its own port number
    tstq_stamp_fifo u_fifo (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .push_i       (push),
        .push_id_i    (tx_stamp_identifier_i),
        .push_port_i  (tx_port_i),
        .push_stamp_i (tx_stamp_i),
        .pop_i        (adv_wr),
        .drop_o       (drop),
        .valid_o      (head_vld),
        .head_id_o    (head_id),
        .head_port_o  (head_port),
        .head_stamp_o (head_stamp),
        .level_o      (level)
    );

////////////////////////////////////////////////////////////////////////
// events and interrupt

    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    assign irq_set[`TSTQ_IRQ_PUSH]    = push && !drop;
    assign irq_set[`TSTQ_IRQ_OVFL]    = drop;
    assign irq_set[`TSTQ_IRQ_UNTRUST] = alloc && pool_untrusted;
    assign irq_clr = (wr_take && hit(adr_i, `TSTQ_ADR_IRQ_STATUS))
                   ? wr_bits[2:0] : 3'h0;

    // a new event in the clearing cycle is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= 3'h0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
        end
    end

////////////////////////////////////////////////////////////////////////
// read data

    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`TSTQ_F_VALID] = head_vld;
        if (head_vld) begin
            status_word[`TSTQ_F_ID_LSB +: 6]   = head_id;
            status_word[`TSTQ_F_PORT_LSB +: 5] = head_port;
        end
        status_word[`TSTQ_F_MAINT] = 1'b0;
        status_word[`TSTQ_F_OVFL]  = irq_stat[`TSTQ_IRQ_OVFL];
    end

    // unmapped and write-only offsets answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_take) begin
            case (adr_i)
                `TSTQ_ADR_HEAD_STATUS: dat_o <= status_word;
                `TSTQ_ADR_HEAD_VALUE:
                    dat_o <= head_vld ? head_stamp : 32'h0;
                `TSTQ_ADR_PORT_DIS:    dat_o <= port_disable;
                `TSTQ_ADR_IRQ_STATUS:  dat_o <= {29'h0, irq_stat};
                `TSTQ_ADR_IRQ_MASK:    dat_o <= {29'h0, irq_mask};
                `TSTQ_ADR_LEVEL:       dat_o <= {24'h0, level};
                default:               dat_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// *** rtl/tstq_stamp_fifo.sv ***
// Purpose: shared transmit stamp queue of 128 entries
// Assumes: push and pop may come in the same cycle
// Notes:   a push into a full queue is dropped and reported
`timescale 1ns/10ps
`include "tstq_defines.svh"
module tstq_stamp_fifo
    import tstq_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  push_i,
    input  tstq_id_t   push_id_i,
    input  tstq_port_t push_port_i,
    input  tstq_stamp_t push_stamp_i,
    input  wire logic  pop_i,
    output logic       drop_o,
    output logic       valid_o,
    output tstq_id_t   head_id_o,
    output tstq_port_t head_port_o,
    output tstq_stamp_t head_stamp_o,
    output logic [7:0] level_o
);
    logic [42:0] mem [`TSTQ_DEPTH];
    logic [6:0]  wr_ptr;
    logic [6:0]  rd_ptr;
    logic [7:0]  level;
    logic        full;
    logic        do_push;
    logic        do_pop;

    assign full    = (level == 8'(`TSTQ_DEPTH));
    assign valid_o = (level != 8'h00);
    assign do_pop  = pop_i && valid_o;
    assign do_push = push_i && !full;
    assign drop_o  = push_i && full;
    assign level_o = level;
    assign {head_id_o, head_port_o, head_stamp_o} = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= {push_id_i, push_port_i, push_stamp_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= 7'h00;
            rd_ptr <= 7'h00;
            level  <= 8'h00;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 7'h01;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 7'h01;
            end
            level <= level + {7'h00, do_push} - {7'h00, do_pop};
        end
    end
endmodule

// *** sim/test_two_step_timestamp_queue.sv ***
// Purpose: self-checking bench of the two-step stamp queue
// Assumes: far-side model drives analyzer and egress inputs
// Notes:   register rows first, then hand-written cases
`timescale 1ns/10ps
module test_two_step_timestamp_queue
    import tstq_pkg::*;
;
typedef struct {logic w; logic [7:0] a; logic [31:0] d, x;} tstq_row_t;
logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
logic [7:0]  adr_i;
logic [3:0]  sel_i;
logic [31:0] dat_i, dat_o, rd;
logic        fv, fc, hv, tv, tc, iv;
logic [2:0]  fo, to;
tstq_stamp_t fr, hr, ts;
tstq_id_t    ti, fid, hd;
tstq_port_t  tp;
int          fails = 0;
int          num_checks = 0;
tstq_id_t    exp_id;
tstq_row_t   rows [10] = '{'{0, 8'h00, 0, 0}, '{0, 8'h04, 0, 0},
    '{0, 8'h20, 0, 0}, '{0, 8'h14, 0, 0}, '{0, 8'h18, 0, 0},
    '{0, 8'h1C, 0, 0}, '{1, 8'h00, 32'hFFFFFFFF, 0}, '{0, 8'h00, 0, 0},
    '{1, 8'h08, 0, 0}, '{0, 8'h24, 0, 0}};

tstq_queue tstq_queue_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .frame_vld_i(fv),
    .rewrite_operation_code_i(fo), .frame_to_cpu_i(fc),
    .frame_rx_stamp_i(fr), .frame_id_vld_o(iv),
    .frame_stamp_identifier_o(fid), .ext_hdr_vld_o(hv),
    .ext_hdr_dscp_o(hd), .ext_hdr_rx_stamp_o(hr), .tx_stamp_vld_i(tv),
    .tx_rewrite_operation_code_i(to), .tx_to_cpu_i(tc),
    .tx_stamp_identifier_i(ti), .tx_port_i(tp), .tx_stamp_i(ts),
    .irq_o);
tstq_far_model far_i (.clk_i, .frame_vld_o(fv), .frame_code_o(fo),
    .frame_cpu_o(fc), .frame_rx_o(fr), .tx_vld_o(tv), .tx_code_o(to),
    .tx_cpu_o(tc), .tx_id_o(ti), .tx_port_o(tp), .tx_stamp_o(ts));

////////////////////////////////////////////////////////////////////////
task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
        $display("unexpected at %0t: got %h exp %h", $time, g, e);
        fails++;
    end
endtask
task automatic check_id(input tstq_id_t g, input tstq_id_t e);
    num_checks++;
    if (g !== e) begin
        $display("unexpected at %0t: id %h exp %h", $time, g, e);
        fails++;
    end
endtask
// master never assumes a latency: only the bound cuts the wait
task automatic wb(input logic w, input logic [7:0] a,
                  input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
        @(posedge clk_i);
        n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) begin
        fails++;
        wrap_up;
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
endtask
task automatic alloc(input logic [2:0] c, input tstq_id_t id);
    far_i.frame(c, 1'b0, 32'h0);
    #1;
    check_word(32'(iv), 32'(c == 3'h3));
    if (c == 3'h3)
        check_id(fid, id);
endtask
function automatic logic [31:0] stat(tstq_id_t id, tstq_port_t p,
                                     logic ov);
    return {18'h0, ov, 1'b0, p, id, 1'b1};
endfunction

////////////////////////////////////////////////////////////////////////
initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
end
initial begin
    #80000;
    fails++;
    wrap_up;
end
initial begin
    {rst_i, cyc_i, stb_i, we_i} = 4'h8;
    {adr_i, sel_i, dat_i} = {8'h00, 4'hF, 32'h0000_0000};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[k]) begin
        wb(rows[k].w, rows[k].a, rows[k].d, rd);
        if (!rows[k].w)
            check_word(rd, rows[k].x);
    end
    exp_id = 6'h04;
    for (int c = 0; c < 8; c++) begin
        alloc(3'(c), exp_id);
        exp_id = exp_id + 6'(c == 3);
    end
    far_i.frame(3'h3, 1'b1, 32'h1234ABCD);
    #1;
    check_id(hd, exp_id);
    check_word(hr, 32'h1234ABCD);
    // exhaust the pool: after 62 only the untrusted value is left
    while (exp_id != 6'h3F) begin
        exp_id++;
        alloc(3'h3, exp_id);
    end
    alloc(3'h3, 6'h3F);
    wb(1'b0, 8'h18, 0, rd);
    check_word(rd, 32'h4);
    wr(8'h0C, 32'h100);
    alloc(3'h3, 6'h28);
    wr(8'h10, 32'h20);
    alloc(3'h3, 6'h05);
    wr(8'h0C, 32'h80000000);
    alloc(3'h3, 6'h3F);
    wr(8'h18, 32'h7);
    wr(8'h1C, 32'h7);
    far_i.stamps(3'h3, 1'b0, 6'h04, 5'h01, 32'hA0000000, 3);
    wb(1'b0, 8'h20, 0, rd);
    check_word(rd, 32'h3);
    check_word(32'(irq_o), 32'h1);
    for (int i = 0; i < 3; i++) begin
        wb(1'b0, 8'h00, 0, rd);
        check_word(rd, stat(6'h04, 5'(i + 1), 1'b0));
        wb(1'b0, 8'h04, 0, rd);
        check_word(rd, 32'hA0000000 + i);
        wr(8'h08, 32'h0);
    end
    wr(8'h18, 32'h7);
    wb(1'b0, 8'h00, 0, rd);
    check_word(rd, 32'h0);
    check_word(32'(irq_o), 32'h0);
    far_i.stamps(3'h3, 1'b0, 6'h09, 5'h00, 32'h0, 129);
    for (int i = 0; i < 128; i++) begin
        wb(1'b0, 8'h00, 0, rd);
        check_word(rd, stat(6'h09, 5'(i), 1'b1));
        wb(1'b0, 8'h04, 0, rd);
        check_word(rd, 32'(i));
        wr(8'h08, 32'h0);
    end
    wr(8'h08, 32'h0);
    wr(8'h18, 32'h7);
    wb(1'b0, 8'h00, 0, rd);
    check_word(rd, 32'h0);
    wr(8'h14, 32'h10);
    far_i.stamps(3'h3, 1'b0, 6'h07, 5'h04, 32'h0, 1);
    far_i.stamps(3'h3, 1'b1, 6'h07, 5'h05, 32'h0, 1);
    for (int c = 0; c < 8; c++)
        far_i.stamps(3'(c), 1'b0, 6'h07, 5'h06, 32'(c), 1);
    wb(1'b0, 8'h20, 0, rd);
    check_word(rd, 32'h1);
    wb(1'b0, 8'h00, 0, rd);
    check_word(rd, stat(6'h07, 5'h06, 1'b0));
    // a reset in mid-run must empty the queue and refill the pool
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    alloc(3'h3, 6'h04);
    wb(1'b0, 8'h20, 0, rd);
    check_word(rd, 32'h0);
    wrap_up;
end
endmodule

// *** sim/tstq_far_model.sv ***
// Purpose: classifier and egress stamper seen from the queue
// Assumes: driven by bench calls, one request per cycle
// Notes:   released stamp and id lines show the inverse of the last value
`timescale 1ns/10ps
module tstq_far_model
    import tstq_pkg::*;
(
    input  wire logic  clk_i,
    output logic       frame_vld_o,
    output logic [2:0] frame_code_o,
    output logic       frame_cpu_o,
    output tstq_stamp_t frame_rx_o,
    output logic       tx_vld_o,
    output logic [2:0] tx_code_o,
    output logic       tx_cpu_o,
    output tstq_id_t   tx_id_o,
    output tstq_port_t tx_port_o,
    output tstq_stamp_t tx_stamp_o
);
initial begin
    {frame_vld_o, frame_code_o, frame_cpu_o, frame_rx_o} = '0;
    {tx_vld_o, tx_code_o, tx_cpu_o, tx_id_o, tx_port_o, tx_stamp_o} = '0;
end
// one classifier decision; the code is what asks for stamping
task automatic frame(input logic [2:0] c, input logic cpu,
                     input tstq_stamp_t rx);
    @(posedge clk_i);
    frame_vld_o <= 1'b1;
    frame_code_o <= c;
    frame_cpu_o <= cpu;
    frame_rx_o <= rx;
    @(posedge clk_i);
    frame_vld_o <= 1'b0;
    frame_rx_o <= ~rx;
endtask
// back-to-back stamps, one per egress port for multicast
task automatic stamps(input logic [2:0] c, input logic cpu,
                      input tstq_id_t id, input tstq_port_t p,
                      input tstq_stamp_t first, input int n);
    for (int i = 0; i < n; i++) begin
        @(posedge clk_i);
        tx_vld_o <= 1'b1;
        tx_code_o <= c;
        tx_cpu_o <= cpu;
        tx_id_o <= id;
        tx_port_o <= p + i[4:0];
        tx_stamp_o <= first + 32'(i);
    end
    @(posedge clk_i);
    tx_vld_o <= 1'b0;
    tx_id_o <= ~id;
    tx_stamp_o <= ~tx_stamp_o;
endtask
endmodule

// *** sim/tstq_queue_asserts.sv ***
// Purpose: port-level checks of the stamp queue
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into tstq_queue after the module
`timescale 1ns/10ps
module tstq_queue_asserts
    import tstq_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        frame_vld_i,
    input wire logic [2:0]  rewrite_operation_code_i,
    input wire logic        frame_to_cpu_i,
    input wire tstq_stamp_t frame_rx_stamp_i,
    input wire logic        frame_id_vld_o,
    input wire tstq_id_t    frame_stamp_identifier_o,
    input wire logic        ext_hdr_vld_o,
    input wire logic [5:0]  ext_hdr_dscp_o,
    input wire tstq_stamp_t ext_hdr_rx_stamp_o,
    input wire logic        irq_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence s_two_step;
    frame_vld_i && rewrite_operation_code_i == 3'h3;
endsequence
sequence s_to_cpu;
    s_two_step ##0 frame_to_cpu_i;
endsequence
a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
a_req_answer: assert property ($rose(cyc_i && stb_i) |=> ack_o)
    else $error("request not answered next cycle");
a_id_answer: assert property (s_two_step |=> frame_id_vld_o)
    else $error("two-step frame got no identifier");
a_id_cause: assert property (frame_id_vld_o |-> $past(frame_vld_i)
    && $past(rewrite_operation_code_i) == 3'h3)
    else $error("identifier without two-step frame");
a_id_range: assert property (frame_id_vld_o
    |-> frame_stamp_identifier_o >= 6'h04)
    else $error("reserved identifier handed out");
a_cpu_header: assert property (s_to_cpu |=> ext_hdr_vld_o
    && ext_hdr_dscp_o == frame_stamp_identifier_o
    && ext_hdr_rx_stamp_o == $past(frame_rx_stamp_i))
    else $error("extraction header fields wrong");
a_rdata_holds: assert property (!(cyc_i && stb_i && !we_i)
    |=> $stable(dat_o))
    else $error("read data moved without a read");
a_reset_quiet: assert property ($fell(rst_i)
    |-> !ack_o && !irq_o && dat_o == 32'h0)
    else $error("outputs not quiet after reset");
endmodule

bind tstq_queue tstq_queue_asserts tstq_queue_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
    .frame_vld_i(frame_vld_i),
    .rewrite_operation_code_i(rewrite_operation_code_i),
    .frame_to_cpu_i(frame_to_cpu_i), .frame_rx_stamp_i(frame_rx_stamp_i),
    .frame_id_vld_o(frame_id_vld_o),
    .frame_stamp_identifier_o(frame_stamp_identifier_o),
    .ext_hdr_vld_o(ext_hdr_vld_o), .ext_hdr_dscp_o(ext_hdr_dscp_o),
    .ext_hdr_rx_stamp_o(ext_hdr_rx_stamp_o), .irq_o(irq_o)
);
